//--- design/rpfb_pkg.sv
// Shared constants and types of the RTP parity repair builder.
package rpfb_pkg;
	localparam int MEM_AW = 11;
	localparam int MEM_DEPTH = 2048;
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_W = 9;
	localparam int MASK_W = 15;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_BASE = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_LD = 8'h0C;
	localparam logic [7:0] REG_OOB = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_REPAIRS = 8'h18;
	localparam int CTRL_F_BIT = 0;
	localparam int CTRL_R_BIT = 1;
	localparam int CTRL_EMIT_BIT = 2;
	localparam int STATUS_BUSY_BIT = 8;
	localparam logic [15:0] RTP_FIXED_LEN = 16'h000C;
	localparam logic [15:0] POS_SEQ_HI = 16'h0002;
	localparam logic [15:0] POS_SEQ_LO = 16'h0003;
	localparam logic [15:0] POS_TS_FIRST = 16'h0004;
	localparam logic [15:0] POS_TS_LAST = 16'h0007;
	localparam logic [15:0] TS_SHIFT = 16'h0004;
	localparam logic [15:0] PAY_SHIFT = 16'h0008;
	localparam logic [15:0] PKT_MAX = 16'h0808;
	localparam logic [15:0] OFF_EMPTY = 16'hFFFF;
	localparam logic K_LAST = 1'b1;
	localparam logic R_OUT = 1'b0;
	typedef enum logic [3:0] {
		ST_CLEAR = 4'h1,
		ST_IDLE = 4'h2,
		ST_RD = 4'h4,
		ST_PUSH = 4'h8
	} rpfb_state_t;
endpackage : rpfb_pkg

//--- design/rpfb_mem.sv
// Byte memory holding the running parity of the current group, registered read.
`timescale 1ns/10ps
module rpfb_mem
	import rpfb_pkg::*;
#(
	parameter int W = 8,
	parameter int AW = MEM_AW
) (
	input wire logic sys_clk, // System clock
	input wire logic we, // Write enable
	input wire logic [AW-1:0] waddr, // Write address
	input wire logic [W-1:0] wdata, // Write data
	input wire logic [AW-1:0] raddr, // Read address
	output logic [W-1:0] rdata // Read data, one cycle after raddr
);
	logic [W-1:0] mem_reg [2**AW];

	// No reset: the owner sweeps the array to zero after reset.
	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem_reg[waddr] <= wdata;
		end
		rdata <= mem_reg[raddr];
	end
endmodule : rpfb_mem

//--- design/rpfb_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module rpfb_fifo #(
	parameter int W = 9,
	parameter int DEPTH = 4
) (
	input wire logic sys_clk, // System clock
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire logic [W-1:0] in_data, // Write data
	input wire logic in_valid, // Write request
	output logic in_ready, // Not full
	output logic [W-1:0] out_data, // Head word
	output logic out_valid, // Not empty
	input wire logic out_ready // Consumer takes head
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] buf_reg [DEPTH];
	logic [PW-1:0] wp_reg, rp_reg;
	logic [PW:0] cnt_reg;
	logic push, pop;

	assign in_ready = cnt_reg != (PW+1)'(DEPTH);
	assign out_valid = cnt_reg != '0;
	assign out_data = buf_reg[rp_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wp_reg <= push ? PW'(wp_reg + 1'b1) : wp_reg;
			rp_reg <= pop ? PW'(rp_reg + 1'b1) : rp_reg;
			cnt_reg <= (PW+1)'(cnt_reg + push - pop);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (push) begin
			buf_reg[wp_reg] <= in_data;
		end
	end
endmodule : rpfb_fifo

//--- design/rpfb_builder.sv
// Top of the RTP parity repair builder: intake, association, accumulation, emission.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module rpfb_builder
	import rpfb_pkg::*;
(
	input wire logic sys_clk, // 125 MHz system clock
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire logic [7:0] reg_addr, // Register byte address
	input wire logic [15:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [15:0] reg_rdata, // Read data, cycle after reg_rd
	input wire logic [7:0] src_data, // Source packet byte
	input wire logic src_valid, // Source byte valid
	input wire logic src_last, // Last byte of source packet
	output logic src_ready, // Builder takes source byte
	output logic [7:0] rep_data, // Repair packet byte
	output logic rep_valid, // Repair byte valid
	output logic rep_last, // Last byte of repair packet
	input wire logic rep_ready // Receiver takes repair byte
);
	rpfb_state_t state_reg, state_next;
	logic f_reg, r_reg, emit_req_reg, member_reg, wr_pend_reg;
	logic [15:0] base_reg, ld_reg, oob_reg, rd_data_reg, pos_reg, off_reg;
	logic [MASK_W-1:0] mask_reg;
	logic [7:0] b0_reg, b1_reg, seqhi_reg, grp_cnt_reg, wr_byte_reg;
	logic [15:0] acc01_reg, len_acc_reg, max_len_reg, min_off_reg, k_reg, rep_cnt_reg;
	logic [MEM_AW-1:0] wr_addr_reg, clr_addr_reg;

	// Maps a byte position to its parity memory slot; positions below 12 are
	// only ever the timestamp here.
	function automatic logic [MEM_AW-1:0] pos_addr(input logic [15:0] p);
		logic [15:0] a;
		a = (p < RTP_FIXED_LEN) ? 16'(p - TS_SHIFT) : 16'(p - PAY_SHIFT);
		pos_addr = a[MEM_AW-1:0];
	endfunction : pos_addr

	// Offsets are tested straight against the association formulas, so the
	// protected set is the same as the reference one.
	function automatic logic is_member(input logic [15:0] off, input logic use_ld,
		input logic [MASK_W-1:0] mask, input logic [7:0] l, input logic [7:0] d);
		logic [3:0] idx;
		logic [15:0] lw;
		logic [15:0] dw;
		idx = 4'(MASK_W - 1) - off[3:0];
		lw = {8'h00, l};
		dw = {8'h00, d};
		if (!use_ld) begin
			is_member = (off < 16'(MASK_W)) && mask[idx];
		end else if (l == 8'h00) begin
			is_member = 1'b0;
		end else if (d == 8'h00) begin
			is_member = off <= lw;
		end else begin
			is_member = (off % lw == 16'h0000) && (off / lw <= dw);
		end
	endfunction : is_member

	// Register decode.
	wire wr_ctrl = reg_wr && reg_addr == REG_CTRL;
	wire wr_base = reg_wr && reg_addr == REG_BASE;
	wire wr_mask = reg_wr && reg_addr == REG_MASK;
	wire wr_ld = reg_wr && reg_addr == REG_LD;
	wire wr_oob = reg_wr && reg_addr == REG_OOB;
	wire busy = state_reg != ST_IDLE;
	wire [15:0] ctrl_val = {13'h0000, emit_req_reg, r_reg, f_reg};
	wire [15:0] status_val = (16'(busy) << STATUS_BUSY_BIT) | {8'h00, grp_cnt_reg};
	wire [15:0] rd_val = (reg_addr == REG_CTRL) ? ctrl_val :
		(reg_addr == REG_BASE) ? base_reg :
		(reg_addr == REG_MASK) ? {1'b0, mask_reg} :
		(reg_addr == REG_LD) ? ld_reg :
		(reg_addr == REG_OOB) ? oob_reg :
		(reg_addr == REG_STATUS) ? status_val :
		(reg_addr == REG_REPAIRS) ? rep_cnt_reg : 16'h0000;
	assign reg_rdata = rd_data_reg;

	// Header L and D of zero hand the offsets over to the session values.
	wire ld_zero = ld_reg == 16'h0000;
	wire [7:0] l_eff = ld_zero ? oob_reg[7:0] : ld_reg[7:0];
	wire [7:0] d_eff = ld_zero ? oob_reg[15:8] : ld_reg[15:8];

	// Emission is only started between packets, never in the middle of one.
	wire idle = state_reg == ST_IDLE;
	wire emit_take = emit_req_reg && idle && pos_reg == 16'h0000 && !wr_pend_reg;
	wire emit_go = emit_take && grp_cnt_reg != 8'h00 && !r_reg;
	assign src_ready = idle && !emit_take;

	// Intake path.
	wire take = src_valid && src_ready;
	wire [15:0] seq_now = {seqhi_reg, src_data};
	wire [15:0] off_now = 16'(seq_now - base_reg);
	wire member_now = !r_reg && is_member(off_now, f_reg, mask_reg, l_eff, d_eff);
	wire at_seq = take && pos_reg == POS_SEQ_LO;
	wire in_hole = pos_reg > POS_TS_LAST && pos_reg < RTP_FIXED_LEN;
	wire keep_pos = pos_reg >= POS_TS_FIRST && !in_hole && pos_reg < PKT_MAX;
	wire store = take && member_reg && keep_pos;
	wire [15:0] pkt_len = 16'(pos_reg + 16'h0001);
	wire fin = take && src_last;
	wire fin_member = fin && member_reg && pkt_len >= RTP_FIXED_LEN;
	wire [15:0] len_field = 16'(pkt_len - RTP_FIXED_LEN);

	// Emission path.
	wire fifo_ready;
	wire [7:0] mem_rdata;
	wire in_push = state_reg == ST_PUSH;
	wire push = in_push && fifo_ready;
	wire k_last = k_reg == 16'(max_len_reg - 16'h0001);
	wire from_mem = (k_reg >= POS_TS_FIRST && k_reg <= POS_TS_LAST) || k_reg >= RTP_FIXED_LEN;
	wire [15:0] seq_base = 16'(base_reg + min_off_reg);
	wire [MASK_W-1:0] mask_out = MASK_W'(mask_reg << min_off_reg);
	logic [7:0] out_byte;

	// Outgoing byte k of the repair packet; the fixed header width keeps the
	// total length equal to that of the longest protected packet.
	always_comb begin
		out_byte = mem_rdata;
		if (k_reg < RTP_FIXED_LEN) begin
			unique case (k_reg[3:0])
				4'h0: out_byte = {R_OUT, f_reg, acc01_reg[13:8]};
				4'h1: out_byte = acc01_reg[7:0];
				4'h2: out_byte = len_acc_reg[15:8];
				4'h3: out_byte = len_acc_reg[7:0];
				4'h4, 4'h5, 4'h6, 4'h7: out_byte = mem_rdata;
				4'h8: out_byte = seq_base[15:8];
				4'h9: out_byte = seq_base[7:0];
				4'hA: out_byte = f_reg ? ld_reg[7:0] : {K_LAST, mask_out[14:8]};
				4'hB: out_byte = f_reg ? ld_reg[15:8] : mask_out[7:0];
				default: out_byte = 8'h00;
			endcase
		end
	end

	// Memory port selection: sweep, accumulate, or read and clear on emission.
	wire [MEM_AW-1:0] mem_raddr = idle ? pos_addr(pos_reg) : pos_addr(k_reg);
	wire sweeping = state_reg == ST_CLEAR;
	wire zero_wr = push && from_mem;
	wire mem_we = sweeping || wr_pend_reg || zero_wr;
	wire [MEM_AW-1:0] mem_waddr = sweeping ? clr_addr_reg :
		wr_pend_reg ? wr_addr_reg : pos_addr(k_reg);
	wire [7:0] acc_byte = mem_rdata ^ wr_byte_reg;
	wire [7:0] mem_wdata = wr_pend_reg ? acc_byte : 8'h00;

	rpfb_mem #(.W(8), .AW(MEM_AW)) u_mem (
		.sys_clk(sys_clk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	rpfb_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.in_data({k_last, out_byte}),
		.in_valid(in_push),
		.in_ready(fifo_ready),
		.out_data({rep_last, rep_data}),
		.out_valid(rep_valid),
		.out_ready(rep_ready)
	);

	// State sequencing.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_CLEAR: state_next = (clr_addr_reg == MEM_AW'(MEM_DEPTH - 1)) ? ST_IDLE : ST_CLEAR;
			ST_IDLE: state_next = emit_go ? ST_RD : ST_IDLE;
			ST_RD: state_next = ST_PUSH;
			ST_PUSH: state_next = push ? (k_last ? ST_IDLE : ST_RD) : ST_PUSH;
		endcase
	end

	wire grp_done = (push && k_last) || (emit_take && !emit_go);
	wire emit_set = wr_ctrl && reg_wdata[CTRL_EMIT_BIT];
	wire [15:0] max_next = (pkt_len > max_len_reg) ? pkt_len : max_len_reg;
	wire [15:0] min_next = (off_reg < min_off_reg) ? off_reg : min_off_reg;

	// Software registers; a new emit request wins over the one being served.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			f_reg <= 1'b0;
			r_reg <= 1'b0;
			emit_req_reg <= 1'b0;
			base_reg <= 16'h0000;
			mask_reg <= '0;
			ld_reg <= 16'h0000;
			oob_reg <= 16'h0000;
			rd_data_reg <= 16'h0000;
		end else begin
			f_reg <= wr_ctrl ? reg_wdata[CTRL_F_BIT] : f_reg;
			r_reg <= wr_ctrl ? reg_wdata[CTRL_R_BIT] : r_reg;
			emit_req_reg <= emit_set || (emit_req_reg && !emit_take);
			base_reg <= wr_base ? reg_wdata : base_reg;
			mask_reg <= wr_mask ? reg_wdata[MASK_W-1:0] : mask_reg;
			ld_reg <= wr_ld ? reg_wdata : ld_reg;
			oob_reg <= wr_oob ? reg_wdata : oob_reg;
			rd_data_reg <= reg_rd ? rd_val : 16'h0000;
		end
	end

	// Packet parse state.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pos_reg <= 16'h0000;
			b0_reg <= 8'h00;
			b1_reg <= 8'h00;
			seqhi_reg <= 8'h00;
			member_reg <= 1'b0;
			off_reg <= 16'h0000;
		end else if (take) begin
			pos_reg <= src_last ? 16'h0000 : pkt_len;
			b0_reg <= (pos_reg == 16'h0000) ? src_data : b0_reg;
			b1_reg <= (pos_reg == 16'h0001) ? src_data : b1_reg;
			seqhi_reg <= (pos_reg == POS_SEQ_HI) ? src_data : seqhi_reg;
			member_reg <= src_last ? 1'b0 : (at_seq ? member_now : member_reg);
			off_reg <= at_seq ? off_now : off_reg;
		end
	end

	// The read issued with a byte returns next cycle, when the XOR is written.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
			wr_byte_reg <= 8'h00;
		end else begin
			wr_pend_reg <= store;
			wr_addr_reg <= pos_addr(pos_reg);
			wr_byte_reg <= src_data;
		end
	end

	// Group accumulators for the fields held outside the memory.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc01_reg <= 16'h0000;
			len_acc_reg <= 16'h0000;
			max_len_reg <= 16'h0000;
			min_off_reg <= OFF_EMPTY;
			grp_cnt_reg <= 8'h00;
		end else if (grp_done) begin
			acc01_reg <= 16'h0000;
			len_acc_reg <= 16'h0000;
			max_len_reg <= 16'h0000;
			min_off_reg <= OFF_EMPTY;
			grp_cnt_reg <= 8'h00;
		end else if (fin_member) begin
			acc01_reg <= acc01_reg ^ {b0_reg, b1_reg};
			len_acc_reg <= len_acc_reg ^ len_field;
			max_len_reg <= max_next;
			min_off_reg <= min_next;
			grp_cnt_reg <= 8'(grp_cnt_reg + 8'h01);
		end
	end

	// Emission counters and the sweep that zeroes the memory after reset.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_CLEAR;
			clr_addr_reg <= '0;
			k_reg <= 16'h0000;
			rep_cnt_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			clr_addr_reg <= sweeping ? MEM_AW'(clr_addr_reg + 1'b1) : clr_addr_reg;
			k_reg <= emit_go ? 16'h0000 : (push ? 16'(k_reg + 16'h0001) : k_reg);
			rep_cnt_reg <= (push && k_last) ? 16'(rep_cnt_reg + 16'h0001) : rep_cnt_reg;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence rd_then_push_s;
		(state_reg == ST_RD && k_reg == 16'h0000) ##1 state_reg == ST_PUSH;
	endsequence

	emit_start_a:
	assert property (emit_go |=> rd_then_push_s)
		else $error("repair emission did not start at byte zero");

	rd_quiet_a:
	assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data present without a read strobe");

	hdr_flags_a:
	assert property (push && k_reg == 16'h0000 |-> out_byte[7:6] == {R_OUT, f_reg})
		else $error("repair header flags wrong");

	rep_length_a:
	assert property (fin_member && !grp_done |=> max_len_reg >= $past(pkt_len))
		else $error("repair length shorter than a protected source");

	len_field_a:
	assert property (fin_member && !grp_done |=>
		len_acc_reg == ($past(len_acc_reg) ^ 16'($past(pos_reg) - 16'h000B)))
		else $error("length field not accumulated as length minus twelve");

	acc_write_a:
	assert property (store |=> mem_we && mem_wdata == (mem_rdata ^ $past(src_data)))
		else $error("payload byte not XORed into parity");

	retrans_none_a:
	assert property (at_seq && r_reg |=> !member_reg)
		else $error("packet associated in retransmission mode");

	mask_msb_a:
	assert property (at_seq && !src_last && !r_reg && !f_reg && off_now == 16'h0000 &&
		mask_reg[MASK_W-1] |=> member_reg)
		else $error("mask bit zero did not protect the base packet");

	seq_base_a:
	assert property (push && k_reg == 16'h0009 |-> out_byte == seq_base[7:0])
		else $error("sequence base byte wrong");

	consec_a:
	assert property (at_seq && !r_reg && f_reg && l_eff != 8'h00 && d_eff == 8'h00 &&
		off_now <= {8'h00, l_eff} && !src_last |=> member_reg)
		else $error("consecutive packet not associated");
endmodule : rpfb_builder

//--- dv/rpfb_far_end.sv
// Far-end model: source packet producer and repair packet receiver.
`timescale 1ns/10ps
module rpfb_far_end (
	input wire logic sys_clk, // System clock
	output logic [7:0] src_data, // Source byte
	output logic src_valid, // Source byte valid
	output logic src_last, // Last source byte
	input wire logic src_ready, // Builder takes byte
	input wire logic [7:0] rep_data, // Repair byte
	input wire logic rep_valid, // Repair byte valid
	input wire logic rep_last, // Last repair byte
	output logic rep_ready // Receiver takes byte
);
	logic [7:0] rx_q[$];
	int pkt_cnt = 0;
	int last_pos = -1;
	bit slow = 1'b0;
	initial begin
		src_data = 8'h00;
		src_valid = 1'b0;
		src_last = 1'b0;
		rep_ready = 1'b0;
	end
	// In slow mode the receiver stalls often, so the four-word FIFO fills and emission waits.
	always @(posedge sys_clk) begin
		if (rep_valid && rep_ready) begin
			rx_q.push_back(rep_data);
			if (rep_last) begin
				last_pos = rx_q.size() - 1;
				pkt_cnt++;
			end
		end
		rep_ready <= slow ? ($urandom_range(3) == 0) : 1'b1;
	end
	task automatic send(input logic [7:0] p[$]);
		@(posedge sys_clk);
		for (int i = 0; i < p.size(); i++) begin
			if ($urandom_range(3) == 0) begin
				src_valid <= 1'b0;
				src_data <= ~src_data; // An idle line must not repeat the last byte.
				@(posedge sys_clk);
			end
			src_valid <= 1'b1;
			src_data <= p[i];
			src_last <= (i == p.size() - 1);
			do @(posedge sys_clk); while (src_ready !== 1'b1);
		end
		src_valid <= 1'b0;
		src_last <= 1'b0;
		src_data <= ~p[p.size() - 1];
	endtask : send
endmodule : rpfb_far_end

//--- dv/testbench.sv
// Self-checking testbench of the RTP parity repair builder.
`timescale 1ns/10ps
module testbench
	import rpfb_pkg::*;
;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [7:0] src_data, rep_data;
	logic src_valid, src_last, src_ready, rep_valid, rep_last, rep_ready;
	int errors = 0;
	int checks_done = 0;
	int n_rep = 0;
	logic [7:0] exp_q[$];
	logic [7:0] pkt[$];
	logic [15:0] rd;

	rpfb_builder i_rpfb_builder (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.src_data(src_data), .src_valid(src_valid), .src_last(src_last), .src_ready(src_ready),
		.rep_data(rep_data), .rep_valid(rep_valid), .rep_last(rep_last), .rep_ready(rep_ready));
	rpfb_far_end i_rpfb_far_end (.sys_clk(sys_clk), .src_data(src_data), .src_valid(src_valid),
		.src_last(src_last), .src_ready(src_ready), .rep_data(rep_data), .rep_valid(rep_valid),
		.rep_last(rep_last), .rep_ready(rep_ready));

	initial begin
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		checks_done++;
		if (seen !== expv) begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask : check

	task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		d = reg_rdata;
	endtask : reg_read

	function automatic logic member(input logic f, input logic [15:0] base, input logic [15:0] mask,
		input logic [7:0] l, input logic [7:0] d, input logic [15:0] seq);
		logic [15:0] off;
		off = seq - base;
		if (!f)
			return off < 15 && mask[14 - off];
		if (d == 8'h00)
			return off <= l;
		return (off % l) == 0 && (off / l) <= d;
	endfunction : member

	function automatic void accumulate(input logic [7:0] p[$]);
		logic [15:0] len;
		len = 16'(p.size() - 12);
		while (exp_q.size() < p.size())
			exp_q.push_back(8'h00);
		exp_q[0] ^= p[0];
		exp_q[1] ^= p[1];
		exp_q[2] ^= len[15:8];
		exp_q[3] ^= len[7:0];
		for (int i = 4; i < 8; i++)
			exp_q[i] ^= p[i];
		for (int i = 12; i < p.size(); i++)
			exp_q[i] ^= p[i];
	endfunction : accumulate

	task automatic run_group(input logic r, input logic f, input logic [15:0] base,
		input logic [15:0] mask, input logic [7:0] l, input logic [7:0] d,
		input logic [7:0] ol, input logic [7:0] od, input int npk);
		logic [7:0] el, ed;
		logic [15:0] seq, lo, ctrl;
		int cnt, p0;
		el = (l == 8'h00 && d == 8'h00) ? ol : l;
		ed = (l == 8'h00 && d == 8'h00) ? od : d;
		exp_q = {};
		cnt = 0;
		lo = 16'hFFFF;
		ctrl = 16'h0000;
		ctrl[CTRL_F_BIT] = f;
		ctrl[CTRL_R_BIT] = r;
		reg_write(REG_CTRL, ctrl);
		reg_write(REG_BASE, base);
		reg_write(REG_MASK, mask);
		reg_read(REG_MASK, rd);
		check(rd, {1'b0, mask[14:0]});
		reg_write(REG_LD, {d, l});
		reg_write(REG_OOB, {od, ol});
		i_rpfb_far_end.slow = $urandom_range(1);
		for (int k = 0; k < npk; k++) begin
			seq = base + 16'(k);
			pkt = {};
			repeat ($urandom_range(40, 12))
				pkt.push_back(8'($urandom));
			pkt[0] = {2'b10, pkt[0][5:0]};
			pkt[2] = seq[15:8];
			pkt[3] = seq[7:0];
			if (!r && member(f, base, mask, el, ed, seq)) begin
				accumulate(pkt);
				cnt++;
				if (lo == 16'hFFFF)
					lo = 16'(k);
			end
			i_rpfb_far_end.send(pkt);
		end
		reg_read(REG_STATUS, rd);
		check(rd[7:0], 8'(cnt));
		p0 = i_rpfb_far_end.pkt_cnt;
		i_rpfb_far_end.rx_q = {};
		ctrl[CTRL_EMIT_BIT] = 1'b1;
		reg_write(REG_CTRL, ctrl);
		for (int t = 0; t < 4000 && i_rpfb_far_end.pkt_cnt == p0; t++)
			@(posedge sys_clk);
		repeat (40) @(posedge sys_clk);
		check(i_rpfb_far_end.pkt_cnt - p0, (cnt > 0) ? 1 : 0);
		if (cnt > 0) begin
			n_rep++;
			exp_q[0] = {1'b0, f, exp_q[0][5:0]};
			{exp_q[8], exp_q[9]} = base + lo;
			{exp_q[10], exp_q[11]} = f ? {l, d} : {1'b1, 15'(mask[14:0] << lo)};
			check(i_rpfb_far_end.rx_q.size(), exp_q.size());
			check(i_rpfb_far_end.last_pos, exp_q.size() - 1);
			for (int i = 0; i < 12; i++)
				check(i_rpfb_far_end.rx_q[i], exp_q[i]);
			for (int i = 12; i < exp_q.size(); i++)
				check(i_rpfb_far_end.rx_q[i], exp_q[i]);
		end
		reg_read(REG_REPAIRS, rd);
		check(rd, 16'(n_rep));
		$display("group done r=%0d f=%0d members=%0d", r, f, cnt);
	endtask : run_group

	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	initial begin
		#480000;
		errors++;
		report_and_stop();
	end

	initial begin
		void'($urandom(32'h50B3));
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		reg_write(REG_REPAIRS, 16'h5A5A);
		reg_write(8'h1C, 16'hFFFF);
		reg_read(REG_REPAIRS, rd);
		check(rd, 16'h0000);
		reg_read(8'h1C, rd);
		check(rd, 16'h0000);
		reg_read(REG_STATUS, rd);
		check(rd, 16'h0001 << STATUS_BUSY_BIT); // The memory sweep is still running here.
		for (int t = 0; t < 3000 && src_ready !== 1'b1; t++)
			@(posedge sys_clk);
		check(src_ready, 1'b1);
		reg_read(REG_STATUS, rd);
		check(rd, 16'h0000);
		$display("register reset test done");
		run_group(1'b0, 1'b0, 16'hFFF8, 16'h7FFF, 8'h00, 8'h00, 8'h00, 8'h00, 15);
		run_group(1'b0, 1'b0, 16'h0100, 16'h1401, 8'h00, 8'h00, 8'h00, 8'h00, 15);
		run_group(1'b0, 1'b1, 16'hFFFE, 16'h0000, 8'h02, 8'h02, 8'h00, 8'h00, 6);
		run_group(1'b0, 1'b1, 16'h0040, 16'h0000, 8'h03, 8'h00, 8'h00, 8'h00, 6);
		run_group(1'b0, 1'b1, 16'h2000, 16'h0000, 8'h00, 8'h00, 8'h02, 8'h03, 8);
		run_group(1'b0, 1'b0, 16'h0500, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00, 3);
		run_group(1'b1, 1'b0, 16'h0600, 16'h7FFF, 8'h00, 8'h00, 8'h00, 8'h00, 3);
		repeat (4)
			run_group(1'b0, 1'($urandom), 16'($urandom), 16'($urandom), 8'($urandom_range(4, 1)),
				8'($urandom_range(3)), 8'h00, 8'h00, 15);
		report_and_stop();
	end
endmodule : testbench
